// ### spindle_servo_pkg.sv
/*
 * Holds the shared constants of the spindle servo settings block, and the
 * hold-period divider that the main module instantiates.
 * Assumes one clock (pclk), an active-low asynchronous reset, and a frame
 * clock level that is already synchronous to pclk.
 *
// How it works
// R01 - digital servo: rough gain from three bits
// R02 - analog servo: rough gain -12dB or 0dB
// R03 - phase and speed gains: -6, 0, +6dB
// R04 - overall gain: 0, +6, +12dB
// R05 - gain, pin fields only with digital servo
// R06 - second pin enabled: both pins follow control
// R07 - second pin disabled: held high impedance
// R08 - pulse width mode: both drives, no wide
// R09 - ternary mode: phase drive, wide allowed
// R10 - bottom hold every 32 or 16 frames
// R11 - peak hold every 4 or 2 frames
// R12 - velocity multiplier one to four
// R13 - speed is (256 - n)/32 times multiplier
// R14 - host keeps multiplier zero outside angular wide
// R15 - fields kept until rewritten
 */

package spindle_servo_pkg;
    // byte addresses of the apb registers
    localparam logic [7:0] ADDR_COEF = 8'h00;
    localparam logic [7:0] ADDR_VEL = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;

    // servo coefficient word fields
    localparam int COEF_PHASE_GAIN_LSB = 6;
    localparam int COEF_SPEED_GAIN_LSB = 4;
    localparam int COEF_OVERALL_LSB = 2;
    localparam int COEF_PHASE_OUT_HI = 1;
    localparam int COEF_PHASE_OUT_LO = 0;
    localparam logic [7:0] COEF_RESET = 8'h00;

    // velocity control word fields
    localparam int VEL_PWM_MODE = 15;
    localparam int VEL_BOTTOM_PERIOD = 14;
    localparam int VEL_PEAK_PERIOD = 13;
    localparam int VEL_ROUGH_EXT = 12;
    localparam int VEL_TARGET_LSB = 4;
    localparam int VEL_MULT_HI = 3;
    localparam int VEL_MULT_LO = 2;
    localparam logic [15:0] VEL_RESET = 16'h0000;

    // control register fields
    localparam int CTRL_DIGITAL_SEL = 0;
    localparam int CTRL_SECOND_PIN = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_WIDE_LINEAR = 4;
    localparam int CTRL_WIDE_ANGULAR = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // gains as signed dB figures
    localparam logic signed [7:0] DB_M12 = -8'sd12;
    localparam logic signed [7:0] DB_M6 = -8'sd6;
    localparam logic signed [7:0] DB_0 = 8'sd0;
    localparam logic signed [7:0] DB_P6 = 8'sd6;
    localparam logic signed [7:0] DB_P12 = 8'sd12;

    // hold periods in frame clock periods
    localparam logic [5:0] BOTTOM_LONG = 6'd32;
    localparam logic [5:0] BOTTOM_SHORT = 6'd16;
    localparam logic [5:0] PEAK_LONG = 6'd4;
    localparam logic [5:0] PEAK_SHORT = 6'd2;

    // velocity numerator base and fraction shift
    localparam logic [8:0] VEL_BASE = 9'd256;
    localparam int VEL_FRAC_BITS = 5;

    // phase comparator pin control codes
    localparam logic [1:0] PIN_PASS = 2'b00;
    localparam logic [1:0] PIN_HIZ = 2'b01;
    localparam logic [1:0] PIN_LOW = 2'b10;
    localparam logic [1:0] PIN_HIGH = 2'b11;

    typedef enum logic [1:0] {
        SERVO_OTHER,
        SERVO_ROUGH,
        SERVO_LOCKED,
        SERVO_HOLD
    } servo_mode_e;
endpackage : spindle_servo_pkg

`timescale 1ns/1ps
`default_nettype none

module hold_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic frame_tick,
    input wire logic run,
    input wire logic [5:0] period,
    output logic hold_pulse
);
    logic [5:0] count_r;

    // count frame ticks, pulse once per period, idle when not running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 6'd0;
            hold_pulse <= 1'b0;
        end else if (!run) begin
            count_r <= 6'd0;
            hold_pulse <= 1'b0;
        end else if (frame_tick) begin
            if (count_r + 6'd1 >= period) begin
                count_r <= 6'd0;
                hold_pulse <= 1'b1;
            end else begin
                count_r <= count_r + 6'd1;
                hold_pulse <= 1'b0;
            end
        end else begin
            hold_pulse <= 1'b0;
        end
    end
endmodule : hold_divider

`default_nettype wire

// ### spindle_servo_config.sv
/*
 * Spindle servo settings: apb register file holding the servo coefficient
 * word, the velocity control word and a control word; decodes gains, drive
 * format, hold pulses, target velocity and phase comparator pin drive.
 * Assumes apb from a single master on pclk and synchronous pin inputs.
 */

`timescale 1ns/1ps
`default_nettype none

module spindle_servo_config (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_clock,
    input wire logic phase_comp_in_a,
    input wire logic phase_comp_in_b,
    output logic phase_comp_out_a,
    output logic phase_comp_oe_a,
    output logic phase_comp_out_b,
    output logic phase_comp_oe_b,
    output logic signed [7:0] rough_servo_gain,
    output logic signed [7:0] phase_gain,
    output logic signed [7:0] speed_gain,
    output logic signed [7:0] overall_gain,
    output logic speed_drive_enable,
    output logic phase_drive_ternary,
    output logic wide_modes_allowed,
    output logic bottom_hold_pulse,
    output logic peak_hold_pulse,
    output logic [10:0] velocity_x32
);
    // two-bit gain field shared by phase and speed
    function automatic logic signed [7:0] gain_pm6(input logic [1:0] code);
        case (code)
            2'b00: gain_pm6 = spindle_servo_pkg::DB_M6;
            2'b01: gain_pm6 = spindle_servo_pkg::DB_0;
            default: gain_pm6 = spindle_servo_pkg::DB_P6;
        endcase
    endfunction : gain_pm6

    // offsets that answer without an error
    function automatic logic reg_mapped(input logic [7:0] addr);
        case (addr)
            spindle_servo_pkg::ADDR_COEF,
            spindle_servo_pkg::ADDR_VEL,
            spindle_servo_pkg::ADDR_CTRL,
            spindle_servo_pkg::ADDR_STAT: reg_mapped = 1'b1;
            default: reg_mapped = 1'b0;
        endcase
    endfunction : reg_mapped

    logic [7:0] coef_r;
    logic [15:0] vel_r;
    logic [5:0] ctrl_r;
    logic frame_prev_r;
    logic mult_misuse_r;
    logic apb_setup;
    logic apb_write;
    logic addr_ok;
    logic [31:0] rd_nxt;
    logic digital_spindle_select;
    logic second_pin_enable;
    logic pulse_width_drive_mode;
    logic bottom_period_bit;
    logic peak_period_bit;
    logic rough_gain_extension;
    logic [7:0] target_velocity_setting;
    logic [1:0] velocity_mult;
    logic [1:0] phase_out_ctl;
    logic [2:0] rough_code;
    logic frame_tick;
    logic [8:0] vel_base;
    logic [10:0] vel_nxt;
    logic signed [7:0] rough_nxt;
    spindle_servo_pkg::servo_mode_e servo_mode;

    // apb phase decode
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready && pwrite;
    assign addr_ok = reg_mapped(paddr);

    // field views of the stored words
    assign digital_spindle_select = ctrl_r[spindle_servo_pkg::CTRL_DIGITAL_SEL];
    assign second_pin_enable = ctrl_r[spindle_servo_pkg::CTRL_SECOND_PIN];
    assign servo_mode = spindle_servo_pkg::servo_mode_e'(ctrl_r[spindle_servo_pkg::CTRL_MODE_LSB +: 2]);
    assign pulse_width_drive_mode = vel_r[spindle_servo_pkg::VEL_PWM_MODE];
    assign bottom_period_bit = vel_r[spindle_servo_pkg::VEL_BOTTOM_PERIOD];
    assign peak_period_bit = vel_r[spindle_servo_pkg::VEL_PEAK_PERIOD];
    assign rough_gain_extension = vel_r[spindle_servo_pkg::VEL_ROUGH_EXT];
    assign target_velocity_setting = vel_r[spindle_servo_pkg::VEL_TARGET_LSB +: 8];
    assign velocity_mult = {vel_r[spindle_servo_pkg::VEL_MULT_HI], vel_r[spindle_servo_pkg::VEL_MULT_LO]};
    assign phase_out_ctl = {coef_r[spindle_servo_pkg::COEF_PHASE_OUT_HI], coef_r[spindle_servo_pkg::COEF_PHASE_OUT_LO]};
    assign rough_code = {coef_r[spindle_servo_pkg::COEF_SPEED_GAIN_LSB +: 2], rough_gain_extension};
    assign frame_tick = frame_clock && !frame_prev_r;

    // apb handshake: setup cycle arms a single access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !addr_ok;
            prdata <= apb_setup ? rd_nxt : 32'h0000_0000;
        end
    end

    // read mux: coefficient and velocity words are write-only and read as zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (!pwrite) begin
            case (paddr)
                spindle_servo_pkg::ADDR_CTRL: rd_nxt = {26'h0, ctrl_r};
                spindle_servo_pkg::ADDR_STAT: rd_nxt = {rough_servo_gain, phase_gain, overall_gain,
                    4'h0, mult_misuse_r, wide_modes_allowed, speed_drive_enable, phase_drive_ternary};
                default: rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // coefficient word kept until the host writes it again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coef_r <= spindle_servo_pkg::COEF_RESET;
        end else if (apb_write && (paddr == spindle_servo_pkg::ADDR_COEF)) begin
            coef_r <= pwdata[7:0]; // R15
        end
    end

    // velocity word kept until the host writes it again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vel_r <= spindle_servo_pkg::VEL_RESET;
        end else if (apb_write && (paddr == spindle_servo_pkg::ADDR_VEL)) begin
            vel_r <= pwdata[15:0]; // R15
        end
    end

    // control word kept until the host writes it again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= spindle_servo_pkg::CTRL_RESET;
        end else if (apb_write && (paddr == spindle_servo_pkg::ADDR_CTRL)) begin
            ctrl_r <= pwdata[5:0]; // R15
        end
    end

    // rough servo gain selection
    always_comb begin
        if (digital_spindle_select) begin
            case (rough_code) // R01
                3'b000: rough_nxt = spindle_servo_pkg::DB_M12;
                3'b001, 3'b010: rough_nxt = spindle_servo_pkg::DB_M6;
                3'b011, 3'b100: rough_nxt = spindle_servo_pkg::DB_0;
                default: rough_nxt = spindle_servo_pkg::DB_P6;
            endcase
        end else begin
            rough_nxt = rough_gain_extension ? spindle_servo_pkg::DB_0 : spindle_servo_pkg::DB_M12; // R02
        end
    end

    // rough gain applies with either servo selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rough_servo_gain <= spindle_servo_pkg::DB_M12;
        end else begin
            rough_servo_gain <= rough_nxt; // R01 R02
        end
    end

    // phase and speed gains only with the digital servo
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_gain <= spindle_servo_pkg::DB_0;
            speed_gain <= spindle_servo_pkg::DB_0;
        end else if (digital_spindle_select) begin // R05
            phase_gain <= gain_pm6(coef_r[spindle_servo_pkg::COEF_PHASE_GAIN_LSB +: 2]); // R03
            speed_gain <= gain_pm6(coef_r[spindle_servo_pkg::COEF_SPEED_GAIN_LSB +: 2]); // R03
        end else begin
            phase_gain <= spindle_servo_pkg::DB_0;
            speed_gain <= spindle_servo_pkg::DB_0;
        end
    end

    // overall gain only with the digital servo
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overall_gain <= spindle_servo_pkg::DB_0;
        end else if (digital_spindle_select) begin // R05
            case (coef_r[spindle_servo_pkg::COEF_OVERALL_LSB +: 2]) // R04
                2'b00: overall_gain <= spindle_servo_pkg::DB_0;
                2'b01: overall_gain <= spindle_servo_pkg::DB_P6;
                default: overall_gain <= spindle_servo_pkg::DB_P12;
            endcase
        end else begin
            overall_gain <= spindle_servo_pkg::DB_0;
        end
    end

    // phase comparator pin drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_comp_out_a <= 1'b0;
            phase_comp_oe_a <= 1'b0;
            phase_comp_out_b <= 1'b0;
            phase_comp_oe_b <= 1'b0;
        end else begin
            case (digital_spindle_select ? phase_out_ctl : spindle_servo_pkg::PIN_PASS) // R05
                spindle_servo_pkg::PIN_PASS: begin // R06
                    phase_comp_out_a <= phase_comp_in_a;
                    phase_comp_out_b <= phase_comp_in_b;
                    phase_comp_oe_a <= 1'b1;
                    phase_comp_oe_b <= second_pin_enable; // R07
                end
                spindle_servo_pkg::PIN_HIZ: begin
                    phase_comp_out_a <= 1'b0;
                    phase_comp_out_b <= 1'b0;
                    phase_comp_oe_a <= 1'b0;
                    phase_comp_oe_b <= 1'b0;
                end
                spindle_servo_pkg::PIN_LOW: begin
                    phase_comp_out_a <= 1'b0;
                    phase_comp_out_b <= 1'b0;
                    phase_comp_oe_a <= 1'b1;
                    phase_comp_oe_b <= second_pin_enable; // R07
                end
                default: begin
                    phase_comp_out_a <= 1'b1;
                    phase_comp_out_b <= 1'b1;
                    phase_comp_oe_a <= 1'b1;
                    phase_comp_oe_b <= second_pin_enable; // R07
                end
            endcase
        end
    end

    // drive format and wide mode permission
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_drive_enable <= 1'b0;
            phase_drive_ternary <= 1'b1;
            wide_modes_allowed <= 1'b1;
        end else begin
            speed_drive_enable <= pulse_width_drive_mode; // R08
            phase_drive_ternary <= !pulse_width_drive_mode; // R09
            wide_modes_allowed <= !pulse_width_drive_mode; // R08 R09
        end
    end

    // host misuse flag: multiplier set outside angular wide mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_misuse_r <= 1'b0;
        end else begin
            mult_misuse_r <= (velocity_mult != 2'b00) && !ctrl_r[spindle_servo_pkg::CTRL_WIDE_ANGULAR]; // R14
        end
    end

    // target velocity in 1/32 units of normal speed
    assign vel_base = spindle_servo_pkg::VEL_BASE - {1'b0, target_velocity_setting}; // R13
    assign vel_nxt = 11'({2'b00, vel_base} * ({9'h0, velocity_mult} + 11'd1)); // R12
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            velocity_x32 <= 11'({2'b00, spindle_servo_pkg::VEL_BASE});
        end else begin
            velocity_x32 <= vel_nxt; // R12 R13
        end
    end

    // frame clock edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_prev_r <= 1'b0;
        end else begin
            frame_prev_r <= frame_clock;
        end
    end

    // bottom hold in rough and hold modes
    hold_divider bottom_div (
        .pclk(pclk),
        .presetn(presetn),
        .frame_tick(frame_tick),
        .run((servo_mode == spindle_servo_pkg::SERVO_ROUGH) || (servo_mode == spindle_servo_pkg::SERVO_HOLD)), // R10
        .period(bottom_period_bit ? spindle_servo_pkg::BOTTOM_SHORT : spindle_servo_pkg::BOTTOM_LONG), // R10
        .hold_pulse(bottom_hold_pulse)
    );

    // peak hold in rough mode only
    hold_divider peak_div (
        .pclk(pclk),
        .presetn(presetn),
        .frame_tick(frame_tick),
        .run(servo_mode == spindle_servo_pkg::SERVO_ROUGH), // R11
        .period(peak_period_bit ? spindle_servo_pkg::PEAK_SHORT : spindle_servo_pkg::PEAK_LONG), // R11
        .hold_pulse(peak_hold_pulse)
    );
endmodule : spindle_servo_config

`default_nettype wire

// ### spindle_servo_monitor.sv
/*
 * Concurrent checks on the ports of the spindle servo settings block.
 * Assumes one clock pclk and the active-low asynchronous reset presetn.
 */
`timescale 1ns/1ps
`default_nettype none
module spindle_servo_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic frame_clock,
    input wire logic phase_comp_oe_a,
    input wire logic phase_comp_oe_b,
    input wire logic signed [7:0] rough_servo_gain,
    input wire logic signed [7:0] overall_gain,
    input wire logic speed_drive_enable,
    input wire logic phase_drive_ternary,
    input wire logic wide_modes_allowed,
    input wire logic peak_hold_pulse,
    input wire logic [10:0] velocity_x32
);
    logic fr_q;
    logic pk_seen;
    logic [7:0] pk_cnt;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // frame rises since the last peak pulse, restarted by any access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fr_q <= 1'b0;
            pk_seen <= 1'b0;
            pk_cnt <= 8'h00;
        end else begin
            fr_q <= frame_clock;
            if (psel && penable) begin
                pk_seen <= 1'b0;
                pk_cnt <= 8'h00;
            end else if (peak_hold_pulse) begin
                pk_seen <= 1'b1;
                pk_cnt <= 8'h00;
            end else if (frame_clock && !fr_q) begin
                pk_cnt <= pk_cnt + 8'h01;
            end
        end
    end
    // apb setup phase
    sequence s_setup;
        psel && !penable;
    endsequence
    chk_apb_answer: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_drive_pair: assert property (speed_drive_enable != phase_drive_ternary)
        else $error("drive format outputs disagree");
    chk_wide_follow: assert property (wide_modes_allowed == phase_drive_ternary)
        else $error("wide mode permission wrong");
    chk_second_pin: assert property (phase_comp_oe_b |-> phase_comp_oe_a)
        else $error("second pin driven alone");
    chk_overall_set: assert property (overall_gain inside {8'sh00, 8'sh06, 8'sh0c})
        else $error("overall gain off table");
    chk_rough_set: assert property (rough_servo_gain inside {-8'sh0c, -8'sh06, 8'sh00, 8'sh06})
        else $error("rough gain off table");
    chk_peak_gap: assert property (peak_hold_pulse && pk_seen |-> pk_cnt == 8'h02 || pk_cnt == 8'h04)
        else $error("peak hold spacing wrong");
    chk_vel_hold: assert property ($changed(velocity_x32) |->
        $past(psel && penable && pwrite && paddr == spindle_servo_pkg::ADDR_VEL, 2))
        else $error("velocity moved without a write");
endmodule : spindle_servo_monitor
bind spindle_servo_config spindle_servo_monitor mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .frame_clock(frame_clock),
    .phase_comp_oe_a(phase_comp_oe_a), .phase_comp_oe_b(phase_comp_oe_b),
    .rough_servo_gain(rough_servo_gain), .overall_gain(overall_gain),
    .speed_drive_enable(speed_drive_enable), .phase_drive_ternary(phase_drive_ternary),
    .wide_modes_allowed(wide_modes_allowed), .peak_hold_pulse(peak_hold_pulse),
    .velocity_x32(velocity_x32)
);
`default_nettype wire

// ### spindle_drive_model.sv
/*
 * Far side model: frame clock of four pclk periods and moving comparators.
 * Assumes pclk runs free; all outputs are synchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none
module spindle_drive_model (
    input wire logic pclk,
    input wire logic presetn,
    output logic frame_clock,
    output logic cmp_a,
    output logic cmp_b
);
    logic [7:0] cnt;
    // free running count sets the frame rate and comparator patterns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
            frame_clock <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
            frame_clock <= cnt[1];
        end
    end
    assign cmp_a = cnt[0];
    assign cmp_b = ~cnt[2];
endmodule : spindle_drive_model
`default_nettype wire

// ### testbench.sv
/*
 * Bench for the spindle servo settings block, driven over apb.
 * Assumes 125 MHz pclk and the far side model for frame and comparators.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic fr, ca, cb, oa, ea, ob, eb, sde, ter, wide, bot, pk;
    logic signed [7:0] rg, pg, sg, og;
    logic [10:0] vx;
    int error_cnt, compares, cyc;
    spindle_servo_config dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_clock(fr), .phase_comp_in_a(ca), .phase_comp_in_b(cb),
        .phase_comp_out_a(oa), .phase_comp_oe_a(ea), .phase_comp_out_b(ob), .phase_comp_oe_b(eb),
        .rough_servo_gain(rg), .phase_gain(pg), .speed_gain(sg), .overall_gain(og),
        .speed_drive_enable(sde), .phase_drive_ternary(ter), .wide_modes_allowed(wide),
        .bottom_hold_pulse(bot), .peak_hold_pulse(pk), .velocity_x32(vx));
    spindle_drive_model far (.pclk(pclk), .presetn(presetn), .frame_clock(fr), .cmp_a(ca), .cmp_b(cb));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // cycle ceiling against hangs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // one apb transfer, then an idle cycle
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        chk(n < 16, 1, "no ready");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // writes that wait until decoded outputs settle
    task automatic wc(input logic [31:0] d);
        apb(spindle_servo_pkg::ADDR_COEF, 1'b1, d);
        @(posedge pclk);
    endtask : wc
    task automatic wv(input logic [31:0] d);
        apb(spindle_servo_pkg::ADDR_VEL, 1'b1, d);
        @(posedge pclk);
    endtask : wv
    task automatic wt(input logic [31:0] d);
        apb(spindle_servo_pkg::ADDR_CTRL, 1'b1, d);
        @(posedge pclk);
    endtask : wt
    function automatic logic signed [7:0] g3(input int c);
        return c == 0 ? -8'sh06 : (c == 1 ? 8'sh00 : 8'sh06);
    endfunction : g3
    // cycles between the 2nd and 3rd pulse; 301 means none seen
    task automatic gap(input logic which, input int exp);
        int n;
        for (int r = 0; r < 3; r++) begin
            n = 0;
            while ((which ? bot : pk) !== 1'b1 && n < 300) begin
                n++;
                @(posedge pclk);
            end
            @(posedge pclk);
        end
        chk(n + 1, exp, "hold gap");
    endtask : gap
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(rg, -8'sh0c, "rough reset");
        chk(vx, 11'h100, "vel reset");
        // analog servo: only the extension bit counts
        wc(32'h55);
        wv(32'h1000);
        chk(rg, 8'sh00, "rough ext");
        chk({og, ea}, 9'h001, "gain and pin off");
        wt(32'h1);
        for (int i = 0; i < 3; i++) begin
            wc({24'h0, i[1:0], i[1:0], i[1:0], 2'b00});
            for (int e = 0; e < 2; e++) begin
                wv({19'h0, e[0], 12'h000});
                chk(pg, g3(i), "phase gain");
                chk(sg, g3(i), "speed gain");
                chk(og, i * 6, "overall gain");
                chk(rg, -12 + 6 * ((2 * i + e + 1) / 2), "rough gain");
            end
        end
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 4; c++) begin
                wt({30'h0, s[0], 1'b1});
                wc({30'h0, c[1:0]});
                chk(ea, c != 1, "oe a");
                chk(eb, s == 1 && c != 1, "oe b");
                if (c > 1) chk(oa, c == 3, "level a");
                if (c > 1 && s == 1) chk(ob, c == 3, "level b");
                if (c == 0) begin
                    rd = {30'h0, cb, ca};
                    @(posedge pclk);
                    chk(oa, rd[0], "pass a");
                    if (s == 1) chk(ob, rd[1], "pass b");
                end
            end
        end
        for (int p = 0; p < 2; p++) begin
            wv({16'h0, p[0], 15'h0});
            chk({sde, ter, wide}, {p[0], !p[0], !p[0]}, "drive format");
        end
        wt(32'h21);
        for (int m = 0; m < 4; m++) begin
            wv({20'h0, 8'(m * 85), m[1:0], 2'b00});
            chk(vx, (256 - m * 85) * (m + 1), "velocity");
        end
        apb(spindle_servo_pkg::ADDR_STAT, 1'b0, 32'h0);
        chk(rd, 32'hf4fa_0005, "status angular");
        wt(32'h1);
        apb(spindle_servo_pkg::ADDR_STAT, 1'b0, 32'h0);
        chk(rd, 32'hf4fa_000d, "status misuse");
        wv(32'h0);
        wt(32'h5);
        for (int b = 0; b < 2; b++) begin
            wv({17'h0, b[0], b[0], 13'h0});
            gap(1'b0, b ? 8 : 16);
            gap(1'b1, b ? 64 : 128);
        end
        wt(32'hd);
        gap(1'b1, 64);
        gap(1'b0, 301);
        wt(32'h9);
        gap(1'b1, 301);
        apb(spindle_servo_pkg::ADDR_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h9, "ctrl readback");
        apb(spindle_servo_pkg::ADDR_COEF, 1'b0, 32'h0);
        chk(rd, 32'h0, "write only reads zero");
        apb(8'h10, 1'b1, 32'hff);
        chk(er, 1'b1, "unmapped error");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
